// ### design/power_clock_manager_regs.vh
`ifndef POWER_CLOCK_MANAGER_REGS_VH
`define POWER_CLOCK_MANAGER_REGS_VH

// ----------------------------------------------------------------
// Clock divide select encodings
// ----------------------------------------------------------------
`define CDIV_RSVD      2'h0
`define CDIV_BY4       2'h1
`define CDIV_BY64      2'h2
`define CDIV_BY1024    2'h3
`define CDIV_RESET     2'h1

// ----------------------------------------------------------------
// Clocks per machine cycle
// ----------------------------------------------------------------
`define CLKS_BY4       11'h004
`define CLKS_BY64      11'h040
`define CLKS_BY1024    11'h400

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define RST_MIN_CLKS   8
`define WARMUP_CLKS    65536
`define WDOG_RST_CLKS  512

`endif

// ### design/rate_divider.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Machine-cycle enable generator
// ----------------------------------------------------------------
module rate_divider (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire [1:0]  sel_i,
  input  wire        restart_i,
  output reg         tick_o
);
`include "power_clock_manager_regs.vh"

  reg  [10:0] count;
  wire [10:0] period;

  // The reserved code falls back to the fastest rate so the core never stalls.
  assign period = (sel_i == `CDIV_BY64)   ? `CLKS_BY64 :
                  (sel_i == `CDIV_BY1024) ? `CLKS_BY1024 : `CLKS_BY4;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count  <= 11'h000;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      count  <= 11'h000;
      tick_o <= 1'b0;
    end else if (count >= period - 11'h001) begin
      count  <= 11'h000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 11'h001;
      tick_o <= 1'b0;
    end
  end
endmodule // rate_divider

// ### design/warmup_timer.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Oscillator warm-up counter
// ----------------------------------------------------------------
module warmup_timer #(
  parameter integer COUNT = 65536
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        start_i,
  input  wire        run_i,
  output reg         busy_o,
  output reg         done_o
);
  reg [16:0] count;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count  <= 17'h00000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count  <= 17'h00000;
        busy_o <= 1'b1;
      end else if (busy_o && run_i) begin
        if (count == COUNT[16:0] - 17'h00001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count + 17'h00001;
        end
      end
    end
  end
endmodule // warmup_timer

// ### design/power_clock_manager.v
`timescale 1ns/1ps
// Overview of operation
// R1: Writing one to the idle request bit enters idle after that instruction.
// R2: Idle stops the CPU clock; interrupt, timer, watchdog and serial clocks keep running.
// R3: Idle drives address latch and program strobes high, ports hold, read/write high.
// R4: Any enabled interrupt in idle clears idle request and resumes execution.
// R5: External reset must stay high eight clocks before it is recognised; in power-down the code takes one synchronised high clock as a reset wake.
// R6: Watchdog runs in idle; time-out interrupt wakes; reset follows 512 clocks later.
// R7: A reset ending idle skips the instruction after the idle-entering one.
// R8: Divide select 01 gives 4, 10 gives 64, 11 gives 1024 clocks; 00 reserved.
// R9: Economy slows all peripherals with the core; idle runs peripherals at clock/4.
// R10: A new divide selection takes effect one instruction cycle after the write.
// R11: Software reaches divide-by-64 or 1024 only from divide-by-4; the code also accepts direct moves between 64 and 1024.
// R12: Source select picks crystal or RC; indicator shows source; change lags one cycle.
// R13: Crystal-off allowed on RC; crystal select refused until crystal ready flag set.
// R14: With switchback enabled, serial or qualified external interrupt forces divide-by-4.
// R15: Switchback on receive start edge with receive enabled, or on transmit buffer write.
// R16: With switchback enabled, divide writes are ignored during serial activity.
// R17: Watchdog, power-on or external reset forces divide-by-4.
// R18: Writing one to power-down request stops all clocks after that instruction.
// R19: Power-down drives address latch and program strobes low, ports show registers.
// R20: Reset in power-down restarts clock, waits 65536 clocks, then resets internally.
// R21: Enabled level-triggered low external interrupt wakes power-down after 65536 clocks.
// R22: RC wake-up select leaves power-down on RC, switching to crystal after warm-up.
`include "power_clock_manager_regs.vh"
module power_clock_manager #(
  parameter integer WARMUP_CLKS   = `WARMUP_CLKS,
  parameter integer WDOG_RST_CLKS = `WDOG_RST_CLKS
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        ext_reset_i,
  input  wire        por_reset_i,
  input  wire        idle_req_wr_i,
  input  wire        pd_req_wr_i,
  input  wire        instr_end_i,
  input  wire        cdiv_wr_i,
  input  wire [1:0]  cdiv_wdata_i,
  input  wire        clock_source_select_i,
  input  wire        crystal_amplifier_off_i,
  input  wire        rc_wakeup_select_i,
  input  wire        switchback_enable_i,
  input  wire        irq_taken_i,
  input  wire        ext_irq_sb_i,
  input  wire        serial_rx_pin_i,
  input  wire        serial_rx_enable_i,
  input  wire        serial_tx_write_i,
  input  wire        serial_busy_i,
  input  wire        external_program_i,
  input  wire        ext_irq_level_n_i,
  input  wire        ext_irq_enable_i,
  input  wire        ext_irq_level_mode_i,
  input  wire        global_interrupt_enable_i,
  input  wire        wdog_timeout_i,
  input  wire        wdog_reset_enable_i,
  input  wire        wdog_restart_i,
  output reg         cpu_clk_en_o,
  output reg         periph_clk_en_o,
  output reg         machine_tick_o,
  output reg         internal_reset_o,
  output reg         skip_next_instr_o,
  output reg         idle_mode_o,
  output reg         power_down_o,
  output reg         wake_irq_o,
  output reg         idle_request_o,
  output reg  [1:0]  clock_divide_select_o,
  output reg         clock_source_indicator_o,
  output reg         crystal_ready_flag_o,
  output reg         crystal_enable_o,
  output reg         addr_latch_strobe_o,
  output reg         program_store_strobe_o,
  output reg         port0_float_o,
  output reg         rd_wr_strobe_high_o,
  output reg         port_hold_o
);

  // ----------------------------------------------------------------
  // Synchronisers for pin inputs
  // ----------------------------------------------------------------
  reg [1:0] rst_sync;
  reg [1:0] rx_sync;
  reg [1:0] irq_sync;
  reg       rx_last;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h0;
      rx_sync  <= 2'h3;
      irq_sync <= 2'h3;
      rx_last  <= 1'b1;
    end else begin
      rst_sync <= {rst_sync[0], ext_reset_i};
      rx_sync  <= {rx_sync[0], serial_rx_pin_i};
      irq_sync <= {irq_sync[0], ext_irq_level_n_i};
      rx_last  <= rx_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Reset recognition and watchdog follow-up
  // ----------------------------------------------------------------
  reg  [3:0]  rst_hold;
  reg  [9:0]  wdog_count;
  reg         wdog_armed;
  reg         rst_pulse;
  wire        ext_rst_seen;
  wire        wdog_fire;

  assign ext_rst_seen = (rst_hold == `RST_MIN_CLKS - 1) && rst_sync[1]; // [R5]
  assign wdog_fire    = wdog_armed && (wdog_count == WDOG_RST_CLKS[9:0] - 10'h001);

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_hold   <= 4'h0;
      wdog_count <= 10'h000;
      wdog_armed <= 1'b0;
    end else begin
      if (!rst_sync[1])
        rst_hold <= 4'h0;
      else if (rst_hold != `RST_MIN_CLKS - 1)
        rst_hold <= rst_hold + 4'h1;
      // The watchdog stays asleep in power-down since its clock is gone.
      if (wdog_restart_i || !wdog_reset_enable_i || wdog_fire) begin
        wdog_armed <= 1'b0;
        wdog_count <= 10'h000;
      end else if (wdog_timeout_i && !wdog_armed) begin
        wdog_armed <= 1'b1; // [R6]
        wdog_count <= 10'h000;
      end else if (wdog_armed && !power_down_o) begin
        wdog_count <= wdog_count + 10'h001; // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle divider
  // ----------------------------------------------------------------
  reg         cdiv_pending;
  reg  [1:0]  cdiv_next;
  reg         src_pending;
  reg         src_next;
  wire        tick;
  wire        serial_start;
  wire        switchback;
  wire        any_reset;
  wire [1:0]  rate_sel;

  assign serial_start = serial_rx_enable_i && rx_last && !rx_sync[1]; // [R15]
  assign switchback   = switchback_enable_i &&
                        (serial_start || serial_tx_write_i || ext_irq_sb_i); // [R14] [R15]
  assign any_reset    = ext_rst_seen || por_reset_i || wdog_fire;
  // Idle keeps the peripherals at clock/4 regardless of economy setting.
  assign rate_sel     = idle_mode_o ? `CDIV_BY4 : clock_divide_select_o; // [R9]

  rate_divider u_rate (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .sel_i     (rate_sel),
    .restart_i (power_down_o),
    .tick_o    (tick)
  );

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clock_divide_select_o <= `CDIV_RESET;
      cdiv_pending          <= 1'b0;
      cdiv_next             <= `CDIV_RESET;
    end else if (any_reset || switchback) begin
      clock_divide_select_o <= `CDIV_BY4; // [R14] [R17]
      cdiv_pending          <= 1'b0;
    end else begin
      if (cdiv_wr_i && !(switchback_enable_i && serial_busy_i) &&
          cdiv_wdata_i != `CDIV_RSVD) begin // [R16] [R8]
        // Moves between 64 and 1024 are left to software discipline.
        cdiv_pending <= 1'b1; // [R11]
        cdiv_next    <= cdiv_wdata_i;
      end else if (cdiv_pending && instr_end_i) begin
        cdiv_pending          <= 1'b0;
        clock_divide_select_o <= cdiv_next; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock source and crystal warm-up
  // ----------------------------------------------------------------
  wire xtal_busy;
  wire xtal_done;
  reg  xtal_on_d;
  wire xtal_start;
  reg  rc_wake_active;
  wire pd_wake_start;

  assign xtal_start = (crystal_enable_o && !xtal_on_d) ||
                      (pd_wake_start && rc_wakeup_select_i);

  warmup_timer #(.COUNT(WARMUP_CLKS)) u_xtal_warm (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (xtal_start),
    .run_i   (crystal_enable_o),
    .busy_o  (xtal_busy),
    .done_o  (xtal_done)
  );

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crystal_enable_o         <= 1'b1;
      xtal_on_d                <= 1'b1;
      crystal_ready_flag_o     <= 1'b1;
      clock_source_indicator_o <= 1'b1;
      src_pending              <= 1'b0;
      src_next                 <= 1'b1;
    end else begin
      xtal_on_d        <= crystal_enable_o;
      // Crystal is switched off by power-down, or by amplifier-off only while running from RC.
      crystal_enable_o <= !(crystal_amplifier_off_i && !clock_source_indicator_o) && !power_down_o; // [R13]
      if (!crystal_enable_o || xtal_start)
        crystal_ready_flag_o <= 1'b0;
      else if (xtal_done)
        crystal_ready_flag_o <= 1'b1; // [R13]
      if (xtal_done && rc_wake_active) begin
        clock_source_indicator_o <= 1'b1; // [R22]
        src_pending              <= 1'b0;
      end else if (pd_wake_start && rc_wakeup_select_i) begin
        clock_source_indicator_o <= 1'b0; // [R22]
      end else if (clock_source_select_i != clock_source_indicator_o && !src_pending &&
                   (crystal_ready_flag_o || !clock_source_select_i)) begin // [R13]
        src_pending <= 1'b1;
        src_next    <= clock_source_select_i;
      end else if (src_pending && instr_end_i) begin
        src_pending              <= 1'b0;
        clock_source_indicator_o <= src_next; // [R12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN      = 3'h0;
  localparam [2:0] ST_IDLE_ARM = 3'h1;
  localparam [2:0] ST_IDLE     = 3'h2;
  localparam [2:0] ST_PD_ARM   = 3'h3;
  localparam [2:0] ST_PD       = 3'h4;
  localparam [2:0] ST_PD_WARM  = 3'h5;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        wake_by_reset;
  reg        pd_irq_wake;
  wire       pd_warm_busy;
  wire       pd_warm_done;
  wire       level_wake;

  assign level_wake    = !irq_sync[1] && ext_irq_enable_i &&
                         global_interrupt_enable_i && ext_irq_level_mode_i; // [R21]
  // The watchdog has no clock in power-down, so only pins can wake it.
  assign pd_wake_start = (state == ST_PD) && (rst_sync[1] || level_wake); // [R20]

  warmup_timer #(.COUNT(WARMUP_CLKS)) u_pd_warm (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (pd_wake_start),
    .run_i   (1'b1),
    .busy_o  (pd_warm_busy),
    .done_o  (pd_warm_done)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (pd_req_wr_i)
          next_state = ST_PD_ARM;
        else if (idle_req_wr_i)
          next_state = ST_IDLE_ARM;
      end
      ST_IDLE_ARM: begin
        if (instr_end_i)
          next_state = ST_IDLE; // [R1]
      end
      ST_IDLE: begin
        if (irq_taken_i || (wdog_timeout_i && wdog_reset_enable_i))
          next_state = ST_RUN; // [R4] [R6]
      end
      ST_PD_ARM: begin
        if (instr_end_i)
          next_state = ST_PD; // [R18]
      end
      ST_PD: begin
        if (pd_wake_start)
          next_state = ST_PD_WARM;
      end
      ST_PD_WARM: begin
        if (pd_warm_done && !pd_warm_busy)
          next_state = ST_RUN; // [R20] [R21]
      end
      default: next_state = ST_RUN;
    endcase
    if (any_reset && state != ST_PD && state != ST_PD_WARM)
      next_state = ST_RUN;
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state             <= ST_RUN;
      wake_by_reset     <= 1'b0;
      rc_wake_active    <= 1'b0;
      pd_irq_wake       <= 1'b0;
      idle_request_o    <= 1'b0;
      internal_reset_o  <= 1'b0;
      skip_next_instr_o <= 1'b0;
      wake_irq_o        <= 1'b0;
    end else begin
      state            <= next_state;
      wake_irq_o       <= 1'b0;
      internal_reset_o <= any_reset && state != ST_PD && state != ST_PD_WARM;
      // An idle exit by reset drops the pending instruction to block stray writes.
      skip_next_instr_o <= any_reset && (state == ST_IDLE); // [R7]
      if (idle_req_wr_i)
        idle_request_o <= 1'b1; // [R1]
      else if ((state == ST_IDLE && next_state == ST_RUN) || any_reset)
        idle_request_o <= 1'b0; // [R4]
      if (pd_wake_start) begin
        wake_by_reset  <= rst_sync[1];
        pd_irq_wake    <= !rst_sync[1];
        rc_wake_active <= rc_wakeup_select_i;
      end
      if (state == ST_PD_WARM && next_state == ST_RUN) begin
        internal_reset_o <= wake_by_reset; // [R20]
        wake_irq_o       <= pd_irq_wake;   // [R21]
        pd_irq_wake      <= 1'b0;
      end
      if (xtal_done)
        rc_wake_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Clock enables and pin states
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_clk_en_o           <= 1'b0;
      periph_clk_en_o        <= 1'b0;
      machine_tick_o         <= 1'b0;
      idle_mode_o            <= 1'b0;
      power_down_o           <= 1'b0;
      addr_latch_strobe_o    <= 1'b0;
      program_store_strobe_o <= 1'b0;
      port0_float_o          <= 1'b0;
      rd_wr_strobe_high_o    <= 1'b0;
      port_hold_o            <= 1'b0;
    end else begin
      idle_mode_o     <= (next_state == ST_IDLE);
      power_down_o    <= (next_state == ST_PD) || (next_state == ST_PD_WARM);
      machine_tick_o  <= tick && !power_down_o;
      cpu_clk_en_o    <= tick && (state == ST_RUN || state == ST_IDLE_ARM ||
                                  state == ST_PD_ARM); // [R2] [R18]
      periph_clk_en_o <= tick && !power_down_o; // [R2] [R9]
      if (state == ST_IDLE) begin
        addr_latch_strobe_o    <= 1'b1; // [R3]
        program_store_strobe_o <= 1'b1;
        port0_float_o          <= external_program_i;
        rd_wr_strobe_high_o    <= 1'b1;
        port_hold_o            <= 1'b1;
      end else if (state == ST_PD || state == ST_PD_WARM) begin
        addr_latch_strobe_o    <= 1'b0; // [R19]
        program_store_strobe_o <= 1'b0;
        port0_float_o          <= external_program_i;
        rd_wr_strobe_high_o    <= 1'b1;
        port_hold_o            <= 1'b1;
      end else begin
        addr_latch_strobe_o    <= 1'b0;
        program_store_strobe_o <= 1'b0;
        port0_float_o          <= 1'b0;
        rd_wr_strobe_high_o    <= 1'b0;
        port_hold_o            <= 1'b0;
      end
    end
  end
endmodule // power_clock_manager

// ### test/pcm_asserts.sv
`timescale 1ns/1ps
`include "power_clock_manager_regs.vh"
module pcm_asserts #(
  parameter integer WARMUP_CLKS   = 65536,
  parameter integer WDOG_RST_CLKS = 512
) (
  input wire       clk_i,
  input wire       nrst_i,
  input wire       ext_reset_i,
  input wire       pd_req_wr_i,
  input wire       instr_end_i,
  input wire       irq_taken_i,
  input wire       switchback_enable_i,
  input wire       serial_tx_write_i,
  input wire       external_program_i,
  input wire       cpu_clk_en_o,
  input wire       periph_clk_en_o,
  input wire       machine_tick_o,
  input wire       internal_reset_o,
  input wire       idle_mode_o,
  input wire       power_down_o,
  input wire       wake_irq_o,
  input wire       idle_request_o,
  input wire [1:0] clock_divide_select_o,
  input wire       addr_latch_strobe_o,
  input wire       program_store_strobe_o,
  input wire       rd_wr_strobe_high_o,
  input wire       port0_float_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire halt = idle_mode_o || power_down_o;
  property p_div_legal; clock_divide_select_o != `CDIV_RSVD; endproperty
  property p_idle_in;
    idle_request_o && instr_end_i && !irq_taken_i && !ext_reset_i && !halt && !pd_req_wr_i |=> idle_mode_o;
  endproperty
  property p_idle_out; idle_mode_o && irq_taken_i |=> !idle_mode_o && !idle_request_o; endproperty
  property p_idle_cpu; idle_mode_o && $past(idle_mode_o) |-> !cpu_clk_en_o; endproperty
  property p_idle_pins;
    idle_mode_o && $past(idle_mode_o) |-> addr_latch_strobe_o && program_store_strobe_o && rd_wr_strobe_high_o;
  endproperty
  property p_pd_pins;
    power_down_o && $past(power_down_o) |-> !addr_latch_strobe_o && !program_store_strobe_o && rd_wr_strobe_high_o;
  endproperty
  property p_pd_clk;
    power_down_o && $past(power_down_o) |-> !cpu_clk_en_o && !periph_clk_en_o && !machine_tick_o;
  endproperty
  property p_float; halt && $past(halt) && $stable(external_program_i) |-> port0_float_o == external_program_i;
  endproperty
  property p_sb_tx; switchback_enable_i && serial_tx_write_i |-> ##[1:4] clock_divide_select_o == `CDIV_BY4;
  endproperty
  property p_rst_div; internal_reset_o |-> ##[0:2] clock_divide_select_o == `CDIV_BY4; endproperty
  property p_by4; machine_tick_o && clock_divide_select_o == `CDIV_BY4 |=> !machine_tick_o [*3]; endproperty
  a_div_legal: assert property (p_div_legal) else $error("reserved divide code shown");
  a_idle_in: assert property (p_idle_in) else $error("idle not entered");
  a_idle_out: assert property (p_idle_out) else $error("idle not ended by interrupt");
  a_idle_cpu: assert property (p_idle_cpu) else $error("cpu clock runs in idle");
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes wrong");
  a_pd_pins: assert property (p_pd_pins) else $error("power-down strobes wrong");
  a_pd_clk: assert property (p_pd_clk) else $error("clock runs in power-down");
  a_float: assert property (p_float) else $error("port 0 float wrong");
  a_sb_tx: assert property (p_sb_tx) else $error("no switchback on transmit");
  a_rst_div: assert property (p_rst_div) else $error("reset kept slow divider");
  a_by4: assert property (p_by4) else $error("divide by 4 tick spacing");
  c_idle: cover property (idle_mode_o);
  c_wake: cover property (wake_irq_o);
  c_sb: cover property (switchback_enable_i && serial_tx_write_i);
  c_rst: cover property (internal_reset_o);
endmodule // pcm_asserts
bind power_clock_manager pcm_asserts #(.WARMUP_CLKS(WARMUP_CLKS), .WDOG_RST_CLKS(WDOG_RST_CLKS)) u_chk (
  .clk_i, .nrst_i, .ext_reset_i, .pd_req_wr_i, .instr_end_i, .irq_taken_i, .switchback_enable_i,
  .serial_tx_write_i, .external_program_i, .cpu_clk_en_o, .periph_clk_en_o, .machine_tick_o,
  .internal_reset_o, .idle_mode_o, .power_down_o, .wake_irq_o, .idle_request_o, .clock_divide_select_o,
  .addr_latch_strobe_o, .program_store_strobe_o, .rd_wr_strobe_high_o, .port0_float_o);

// ### test/core_model.sv
`timescale 1ns/1ps
// ----
// Core stand-in: two machine cycles per instruction.
// ----
module core_model (
  input  wire clk_i,
  input  wire nrst_i,
  input  wire machine_tick_i,
  input  wire halt_i,
  output reg  instr_end_o
);
  reg ph;
  // A halted core finishes no instruction, so idle entry rests on the last one.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph          <= 1'b0;
      instr_end_o <= 1'b0;
    end else begin
      instr_end_o <= machine_tick_i && ph && !halt_i;
      if (machine_tick_i) ph <= !ph;
    end
  end
endmodule // core_model

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "power_clock_manager_regs.vh"
module tb_top;
  localparam integer W = 16;
  reg        clk_i = 1'b0, nrst_i = 1'b0, xr = 1'b0, sbe = 1'b0, busy = 1'b0, rx = 1'b1, rxe = 1'b0;
  reg        xp = 1'b1, csel = 1'b1, rcw = 1'b0, irq_n = 1'b1, ien = 1'b0, lvl = 1'b0, gie = 1'b0, por = 1'b0;
  reg  [5:0] pl = 6'h00;
  reg  [1:0] wd = 2'h1, v;
  integer    errors = 0, compares = 0, i, n, r;
  wire       ie, cpu, per, tick, irst, skip, idle, pd, wake, ireq, src, xrdy, xen, al, ps, p0f, rw, ph;
  wire [1:0] div;
  wire [4:0] ev = {ie, wake, irst, pd, idle};
  initial forever #5 clk_i = ~clk_i;
  core_model u_core (.clk_i(clk_i), .nrst_i(nrst_i), .machine_tick_i(tick), .halt_i(idle | pd), .instr_end_o(ie));
  power_clock_manager #(.WARMUP_CLKS(W), .WDOG_RST_CLKS(8)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ext_reset_i(xr), .por_reset_i(por), .idle_req_wr_i(pl[0]),
    .pd_req_wr_i(pl[1]), .instr_end_i(ie), .cdiv_wr_i(pl[2]), .cdiv_wdata_i(wd),
    .clock_source_select_i(csel), .crystal_amplifier_off_i(1'b0), .rc_wakeup_select_i(rcw),
    .switchback_enable_i(sbe), .irq_taken_i(pl[3]), .ext_irq_sb_i(pl[5]), .serial_rx_pin_i(rx),
    .serial_rx_enable_i(rxe), .serial_tx_write_i(pl[4]), .serial_busy_i(busy), .external_program_i(xp),
    .ext_irq_level_n_i(irq_n), .ext_irq_enable_i(ien), .ext_irq_level_mode_i(lvl),
    .global_interrupt_enable_i(gie), .wdog_timeout_i(1'b0), .wdog_reset_enable_i(1'b0),
    .wdog_restart_i(1'b0), .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .machine_tick_o(tick),
    .internal_reset_o(irst), .skip_next_instr_o(skip), .idle_mode_o(idle), .power_down_o(pd),
    .wake_irq_o(wake), .idle_request_o(ireq), .clock_divide_select_o(div), .clock_source_indicator_o(src),
    .crystal_ready_flag_o(xrdy), .crystal_enable_o(xen), .addr_latch_strobe_o(al),
    .program_store_strobe_o(ps), .port0_float_o(p0f), .rd_wr_strobe_high_o(rw), .port_hold_o(ph));
  // ----
  // Shared tasks
  // ----
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task pulse(input integer b);
    begin
      @(posedge clk_i) pl[b] <= 1'b1;
      @(posedge clk_i) pl[b] <= 1'b0;
    end
  endtask
  // Waits are sampled at the falling edge, where registered outputs have settled.
  task wait_ev(input integer b, input integer lim);
    begin
      n = 0;
      @(negedge clk_i);
      while (ev[b] !== 1'b1 && n < lim) begin
        @(negedge clk_i);
        n = n + 1;
      end
    end
  endtask
  task wdiv(input [1:0] c);
    begin
      wait_ev(4, 5000);
      @(posedge clk_i) begin wd <= c; pl[2] <= 1'b1; end
      @(posedge clk_i) pl[2] <= 1'b0;
    end
  endtask
  function [1:0] exp_div(input [1:0] cur, input [1:0] c);
    exp_div = (c == `CDIV_RSVD || (sbe && busy)) ? cur : c;
  endfunction
  task final_report;
    begin
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #900000;
    errors = errors + 1;
    final_report;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    r = $urandom(43);
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk("div", `CDIV_RESET, div);
    chk("src xrdy", 16'h0007, {src, xrdy, xen});
    for (i = 0; i < 6; i = i + 1) begin
      r = $urandom;
      v = (r % 3 == 0) ? `CDIV_RSVD : (r[4] ? `CDIV_BY64 : `CDIV_BY1024);
      wdiv(v);
      @(negedge clk_i) chk("div hold", `CDIV_BY4, div);
      wait_ev(4, 5000);
      repeat (2) @(negedge clk_i);
      chk("div new", exp_div(`CDIV_BY4, v), div);
      wdiv(`CDIV_BY4);
      wait_ev(4, 5000);
      repeat (2) @(negedge clk_i);
      chk("div back", `CDIV_BY4, div);
    end
    @(posedge clk_i) begin sbe <= 1'b1; rxe <= 1'b1; end
    for (i = 0; i < 3; i = i + 1) begin
      wdiv(`CDIV_BY64);
      wait_ev(4, 300);
      repeat (2) @(negedge clk_i);
      chk("eco", `CDIV_BY64, div);
      if (i == 0) pulse(4);
      else if (i == 1) pulse(5);
      else begin
        @(posedge clk_i) rx <= 1'b0;
        repeat (6) @(posedge clk_i);
        rx <= 1'b1;
      end
      repeat (6) @(negedge clk_i);
      chk("switchback", `CDIV_BY4, div);
    end
    @(posedge clk_i) busy <= 1'b1;
    wdiv(`CDIV_BY64);
    wait_ev(4, 300);
    repeat (2) @(negedge clk_i);
    chk("busy write", exp_div(`CDIV_BY4, `CDIV_BY64), div);
    @(posedge clk_i) begin busy <= 1'b0; sbe <= 1'b0; xp <= r[7]; end
    pulse(0);
    wait_ev(0, 200);
    chk("idle", 16'h0001, idle);
    r = 0;
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      r = r + cpu;
      n = n + per;
    end
    chk("idle cpu", 16'h0000, r);
    chk("idle periph", 16'h000A, n);
    chk("idle pins", 16'h000F, {al, ps, rw, ph});
    chk("idle p0", xp, p0f);
    pulse(3);
    @(negedge clk_i) chk("idle end", 16'h0000, {idle, ireq, skip});
    @(posedge clk_i) begin ien <= 1'b1; lvl <= 1'b1; gie <= 1'b1; rcw <= 1'b1; end
    pulse(1);
    wait_ev(1, 200);
    @(negedge clk_i) chk("pd pins", 16'h0003, {al, ps, rw, ph});
    @(posedge clk_i) irq_n <= 1'b0;
    wait_ev(3, 2000);
    chk("wake seen", 16'h0001, wake);
    chk("wake delay", 16'h0001, n >= W);
    @(posedge clk_i) irq_n <= 1'b1;
    repeat (W + 8) @(negedge clk_i);
    chk("rc wake src", 16'h0001, src);
    pulse(1);
    wait_ev(1, 200);
    @(posedge clk_i) xr <= 1'b1;
    wait_ev(2, 2000);
    chk("pd reset", 16'h0001, irst);
    chk("pd reset delay", 16'h0001, n >= W);
    @(posedge clk_i) xr <= 1'b0;
    repeat (4) @(posedge clk_i);
    wdiv(`CDIV_BY64);
    @(posedge clk_i) xr <= 1'b1;
    repeat (5) @(posedge clk_i);
    xr <= 1'b0;
    wait_ev(2, 20);
    chk("short reset", 16'h0002, {irst, div});
    @(posedge clk_i) xr <= 1'b1;
    repeat (12) @(posedge clk_i);
    xr <= 1'b0;
    wait_ev(2, 20);
    chk("long reset", 16'h0001, irst);
    repeat (4) @(negedge clk_i);
    chk("reset div", `CDIV_BY4, div);
    wdiv(`CDIV_BY64);
    repeat (12) @(negedge clk_i);
    @(posedge clk_i) por <= 1'b1;
    @(posedge clk_i) por <= 1'b0;
    @(negedge clk_i) chk("por", 16'h0005, {irst, div});
    final_report;
  end
endmodule // tb_top
